/* shared/card_cmd_pkg.sv */
// constants for the card command decoder
package card_cmd_pkg;
  localparam logic [7:0] CLA_PROP = 8'h80;
  localparam logic [7:0] CLA_STD = 8'h00;
  localparam logic [7:0] CLA_STD_SM = 8'h0C;
  localparam logic [7:0] CLA_SM_ENC = 8'h8C;
  localparam logic [7:0] CLA_SM_MAC = 8'h84;
  localparam logic [7:0] INS_INIT = 8'hA8;
  localparam logic [7:0] INS_AUTH = 8'h88;
  localparam logic [7:0] INS_PIN = 8'h24;
  localparam logic [7:0] TAG_OPTIONS = 8'h83;
  localparam logic [7:0] TAG_PRIM = 8'h80;
  localparam logic [7:0] TAG_CONS = 8'h79;
  localparam logic [7:0] TAG_PROFILE = 8'h82;
  localparam logic [7:0] TAG_LOCATOR = 8'h94;
  localparam logic [7:0] TAG_SIGNED_HI = 8'h9F;
  localparam logic [7:0] TAG_SIGNED_LO = 8'h4B;
  localparam logic [7:0] PROFILE_LEN = 8'h02;
  localparam logic [7:0] PIN_UNBLOCK = 8'h00;
  localparam logic [7:0] PIN_CHANGE_CUR = 8'h01;
  localparam logic [7:0] PIN_CHANGE_NEW = 8'h02;
  localparam logic [15:0] P1P2_ZERO = 16'h0000;
  localparam logic [15:0] SW_OK = 16'h9000;
  localparam logic [15:0] SW_CORRUPT = 16'h6281;
  localparam logic [15:0] SW_NO_INFO = 16'h6200;
  localparam logic [15:0] SW_NVM_SAME = 16'h6400;
  localparam logic [15:0] SW_MEM_FAIL = 16'h6581;
  localparam logic [15:0] SW_WRONG_LEN = 16'h6700;
  localparam logic [15:0] SW_NO_SM = 16'h6882;
  localparam logic [15:0] SW_SEC_STATUS = 16'h6982;
  localparam logic [15:0] SW_REF_INVALID = 16'h6984;
  localparam logic [15:0] SW_COND = 16'h6985;
  localparam logic [15:0] SW_SM_MISSING = 16'h6987;
  localparam logic [15:0] SW_SM_WRONG = 16'h6988;
  localparam logic [15:0] SW_BAD_DATA = 16'h6A80;
  localparam logic [15:0] SW_NO_FUNC = 16'h6A81;
  localparam logic [15:0] SW_BAD_P1P2 = 16'h6A86;
  localparam logic [15:0] SW_REF_MISSING = 16'h6A88;
  localparam logic [15:0] SW_BAD_INS = 16'h6D00;
  localparam logic [8:0] HDR_BYTES = 9'h004;
  localparam logic [8:0] LC_POS = 9'h004;
  localparam logic [8:0] DATA_POS = 9'h005;
  localparam logic [8:0] CNT_MAX = 9'h1FF;
endpackage

/* shared/resp_if.sv */
// response buffer hand-off between decoder and serializer
`timescale 1ns/10ps
interface resp_if #(parameter int RESP_MAX = 96);
  logic load;
  logic [7:0] len;
  logic [RESP_MAX-1:0][7:0] bytes;
  logic busy;
  modport src (output load, output len, output bytes, input busy);
  modport dst (input load, input len, input bytes, output busy);
endinterface

/* design/resp_serializer.sv */
// sends a prepared response buffer byte by byte
`timescale 1ns/10ps
module resp_serializer #(
  parameter int RESP_MAX = 96
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  resp_if.dst buffer,
  output logic respValid,
  output logic [7:0] respByte,
  output logic respLast,
  input wire logic respReady
);
  typedef struct packed {
    logic valid;
    logic [7:0] idx;
    logic [7:0] data;
  } ser_t;

  ser_t cur_q, nxt_d;

  always_comb
  begin
    nxt_d = cur_q;
    if (buffer.load)
    begin
      nxt_d.valid = 1'b1;
      nxt_d.idx = 8'h00;
      nxt_d.data = buffer.bytes[0];
    end
    else if (cur_q.valid && respReady)
    begin
      if (cur_q.idx + 8'h01 >= buffer.len)
        nxt_d.valid = 1'b0;
      else
      begin
        nxt_d.idx = cur_q.idx + 8'h01;
        nxt_d.data = buffer.bytes[cur_q.idx + 8'h01];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      cur_q <= '0;
    else
      cur_q <= nxt_d;
  end

  // buffer must stay stable while busy; the decoder waits for it
  assign buffer.busy = cur_q.valid;
  assign respValid = cur_q.valid;
  assign respByte = cur_q.data;
  assign respLast = cur_q.valid && (cur_q.idx + 8'h01 >= buffer.len);
endmodule

/* design/card_txn_auth_pin_cmd_decoder.sv */
// card-side decoder for transaction init, internal auth and pin change
//
// Summary of operation
// - transaction init is class 80, ins A8, P1 P2 00 00, expected length 00; the decoder accepts any Le byte value, only its presence is checked.
// - format one answer is tag 80 holding profile then locator, no delimiters.
// - format two answer is tag 79 always holding profile and locator objects.
// - success of every command is status 9000 after any data.
// - warning 62 81 marks possibly corrupted returned data, all three commands.
// - init errors only 64 00, 67 00, 69 85, 6A 81.
// - internal auth is class 00, ins 88, P1 P2 00, data length, expected 00; the decoder accepts any Le byte value, only its presence is checked.
// - auth P1 carries no algorithm; algorithm is known or in the data.
// - auth answer is tag 80 signed data, or tag 79 containing it.
// - auth errors 64 00, 67 00, 68 82, 69 85, 6A 80, 6A 86.
// - successful pin command reloads try counter; pin replaced only when asked.
// - pin command class 8C or 84, ins 24, P1 00, P2 00-02, no expected length.
// - P2 00 only unblocks and reloads counter; reference pin kept.
// - P2 01 uses current pin, replaces it, reloads counter.
// - P2 02 replaces pin without current pin, reloads counter.
// - pin command answers only with the status word.
// - pin command warns 62 00; errors 6400 6581 6982 6984 6987 6988 6A86 6A88.
`timescale 1ns/10ps
module card_txn_auth_pin_cmd_decoder #(
  parameter int LOC_MAX = 16,
  parameter int SIGN_MAX = 64,
  parameter int PIN_BYTES = 8,
  parameter int MAC_BYTES = 8,
  parameter int TRY_BITS = 4,
  parameter logic [3:0] TRY_LIMIT = 4'h3
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic cmdValid,
  input wire logic [7:0] cmdByte,
  input wire logic cmdEnd,
  output logic cmdReady,
  output logic respValid,
  output logic [7:0] respByte,
  output logic respLast,
  input wire logic respReady,
  input wire logic useFormatTwo,
  input wire logic [15:0] interchangeProfile,
  input wire logic [LOC_MAX-1:0][7:0] fileLocatorList,
  input wire logic [7:0] fileLocatorLen,
  input wire logic signedValid,
  input wire logic [SIGN_MAX-1:0][7:0] signedData,
  input wire logic [7:0] signedLen,
  input wire logic condsOk,
  input wire logic dataCorrupt,
  input wire logic noInfoWarn,
  input wire logic nvmFault,
  input wire logic memFail,
  input wire logic macOk,
  input wire logic secStatusOk,
  input wire logic pinCurrentOk,
  input wire logic pinTryDecrement,
  output logic [TRY_BITS-1:0] pinTryCounter,
  output logic pinBlocked,
  output logic [PIN_BYTES-1:0][7:0] referencePin,
  output logic referencePinValid
);
  localparam int RESP_MAX = SIGN_MAX + LOC_MAX + 16;

  typedef enum logic [1:0] {COLLECT, EXEC, SEND} phase_t;

  typedef struct packed {
    phase_t phase;
    logic [3:0][7:0] hdr;
    logic [7:0] lc;
    logic [8:0] cnt;
    logic leSeen;
    logic overrun;
    logic [PIN_BYTES-1:0][7:0] head;
    logic [PIN_BYTES-1:0][7:0] refPin;
    logic refValid;
    logic [TRY_BITS-1:0] tries;
    logic [RESP_MAX-1:0][7:0] resp;
    logic [7:0] respLen;
    logic load;
  } state_t;

  state_t cur_q, nxt_d;

  resp_if #(.RESP_MAX(RESP_MAX)) respBus ();

  always_comb
  begin
    logic [7:0] cla;
    logic [7:0] ins;
    logic [7:0] p1;
    logic [7:0] p2;
    logic [8:0] dataEnd;
    logic [8:0] dIdx;
    logic bodyOk;
    logic [15:0] sw;
    logic sendData;
    logic isInit;
    logic isAuth;
    logic isPin;
    logic pinOk;
    logic [7:0] locN;
    logic [7:0] sigN;
    logic [7:0] expLc;
    int k;
    cla = cur_q.hdr[0];
    ins = cur_q.hdr[1];
    p1 = cur_q.hdr[2];
    p2 = cur_q.hdr[3];
    dataEnd = {1'b0, cur_q.lc} + card_cmd_pkg::DATA_POS;
    dIdx = cur_q.cnt - card_cmd_pkg::DATA_POS;
    bodyOk = (cur_q.cnt >= dataEnd) && !cur_q.overrun;
    sw = card_cmd_pkg::SW_BAD_INS;
    sendData = 1'b0;
    pinOk = 1'b0;
    k = 0;
    locN = (fileLocatorLen > 8'(LOC_MAX)) ? 8'(LOC_MAX) : fileLocatorLen;
    sigN = (signedLen > 8'(SIGN_MAX)) ? 8'(SIGN_MAX) : signedLen;
    expLc = (p2 == card_cmd_pkg::PIN_UNBLOCK) ? 8'(MAC_BYTES) : 8'(PIN_BYTES + MAC_BYTES);
    isInit = (cla == card_cmd_pkg::CLA_PROP) && (ins == card_cmd_pkg::INS_INIT);
    isAuth = (ins == card_cmd_pkg::INS_AUTH)
      && (cla == card_cmd_pkg::CLA_STD || cla == card_cmd_pkg::CLA_STD_SM);
    isPin = (ins == card_cmd_pkg::INS_PIN)
      && (cla == card_cmd_pkg::CLA_SM_ENC || cla == card_cmd_pkg::CLA_SM_MAC);
    nxt_d = cur_q;
    nxt_d.load = 1'b0;
    // verification outside the block burns tries; no wrap below zero
    if (pinTryDecrement && cur_q.tries != '0)
      nxt_d.tries = cur_q.tries - 1'b1;
    case (cur_q.phase)
      COLLECT:
      begin
        if (cmdValid)
        begin
          if (cur_q.cnt < card_cmd_pkg::HDR_BYTES)
            nxt_d.hdr[cur_q.cnt[1:0]] = cmdByte;
          else if (cur_q.cnt == card_cmd_pkg::LC_POS)
            nxt_d.lc = cmdByte;
          else if (cur_q.cnt < dataEnd)
          begin
            // only the leading bytes matter here; mac is checked outside
            if (dIdx < 9'(PIN_BYTES))
              nxt_d.head[dIdx[$clog2(PIN_BYTES)-1:0]] = cmdByte;
          end
          else if (cur_q.cnt == dataEnd && !cur_q.leSeen)
            nxt_d.leSeen = 1'b1;
          else
            nxt_d.overrun = 1'b1;
          if (cur_q.cnt != card_cmd_pkg::CNT_MAX)
            nxt_d.cnt = cur_q.cnt + 9'h001;
          if (cmdEnd)
            nxt_d.phase = EXEC;
        end
      end
      EXEC:
      begin
        if (isInit)
        begin
          if (nvmFault)
            sw = card_cmd_pkg::SW_NVM_SAME;
          else if (!cur_q.leSeen || !bodyOk || cur_q.cnt <= card_cmd_pkg::LC_POS)
            sw = card_cmd_pkg::SW_WRONG_LEN;
          else if ({p1, p2} != card_cmd_pkg::P1P2_ZERO)
            sw = card_cmd_pkg::SW_NO_FUNC;
          else if (cur_q.lc < 8'h02 || cur_q.head[0] != card_cmd_pkg::TAG_OPTIONS
            || cur_q.head[1] != cur_q.lc - 8'h02)
            sw = card_cmd_pkg::SW_COND;
          else if (!condsOk)
            sw = card_cmd_pkg::SW_COND;
          else
          begin
            sendData = 1'b1;
            if (useFormatTwo)
            begin
              nxt_d.resp[0] = card_cmd_pkg::TAG_CONS;
              nxt_d.resp[1] = locN + 8'h06;
              nxt_d.resp[2] = card_cmd_pkg::TAG_PROFILE;
              nxt_d.resp[3] = card_cmd_pkg::PROFILE_LEN;
              nxt_d.resp[4] = interchangeProfile[15:8];
              nxt_d.resp[5] = interchangeProfile[7:0];
              nxt_d.resp[6] = card_cmd_pkg::TAG_LOCATOR;
              nxt_d.resp[7] = locN;
              k = 8;
            end
            else
            begin
              nxt_d.resp[0] = card_cmd_pkg::TAG_PRIM;
              nxt_d.resp[1] = locN + card_cmd_pkg::PROFILE_LEN;
              nxt_d.resp[2] = interchangeProfile[15:8];
              nxt_d.resp[3] = interchangeProfile[7:0];
              k = 4;
            end
            for (int i = 0; i < LOC_MAX; i++)
            begin
              if (8'(i) < locN)
              begin
                nxt_d.resp[k] = fileLocatorList[i];
                k = k + 1;
              end
            end
          end
        end
        else if (isAuth)
        begin
          if (nvmFault)
            sw = card_cmd_pkg::SW_NVM_SAME;
          else if (cla == card_cmd_pkg::CLA_STD_SM)
            sw = card_cmd_pkg::SW_NO_SM;
          else if (!cur_q.leSeen || !bodyOk || cur_q.cnt <= card_cmd_pkg::LC_POS)
            sw = card_cmd_pkg::SW_WRONG_LEN;
          else if ({p1, p2} != card_cmd_pkg::P1P2_ZERO)
            sw = card_cmd_pkg::SW_BAD_P1P2;
          else if (cur_q.lc == 8'h00)
            sw = card_cmd_pkg::SW_BAD_DATA;
          else if (!condsOk || !signedValid)
            sw = card_cmd_pkg::SW_COND;
          else
          begin
            sendData = 1'b1;
            if (useFormatTwo)
            begin
              nxt_d.resp[0] = card_cmd_pkg::TAG_CONS;
              nxt_d.resp[1] = sigN + 8'h03;
              nxt_d.resp[2] = card_cmd_pkg::TAG_SIGNED_HI;
              nxt_d.resp[3] = card_cmd_pkg::TAG_SIGNED_LO;
              nxt_d.resp[4] = sigN;
              k = 5;
            end
            else
            begin
              nxt_d.resp[0] = card_cmd_pkg::TAG_PRIM;
              nxt_d.resp[1] = sigN;
              k = 2;
            end
            for (int i = 0; i < SIGN_MAX; i++)
            begin
              if (8'(i) < sigN)
              begin
                nxt_d.resp[k] = signedData[i];
                k = k + 1;
              end
            end
          end
        end
        else if (isPin)
        begin
          if (nvmFault)
            sw = card_cmd_pkg::SW_NVM_SAME;
          else if (p1 != 8'h00 || p2 > card_cmd_pkg::PIN_CHANGE_NEW)
            sw = card_cmd_pkg::SW_BAD_P1P2;
          else if (cur_q.cnt <= card_cmd_pkg::LC_POS || cur_q.lc < 8'(MAC_BYTES))
            sw = card_cmd_pkg::SW_SM_MISSING;
          else if (cur_q.leSeen || !bodyOk || cur_q.lc != expLc || !macOk)
            sw = card_cmd_pkg::SW_SM_WRONG;
          else if (!secStatusOk)
            sw = card_cmd_pkg::SW_SEC_STATUS;
          else if (p2 == card_cmd_pkg::PIN_CHANGE_CUR && !cur_q.refValid)
            sw = card_cmd_pkg::SW_REF_MISSING;
          else if (p2 == card_cmd_pkg::PIN_CHANGE_CUR && !pinCurrentOk)
            sw = card_cmd_pkg::SW_REF_INVALID;
          else if (memFail)
            sw = card_cmd_pkg::SW_MEM_FAIL;
          else
            pinOk = 1'b1;
          if (pinOk)
          begin
            nxt_d.tries = TRY_BITS'(TRY_LIMIT);
            // pin component is stored still enciphered; cipher lives outside
            if (p2 != card_cmd_pkg::PIN_UNBLOCK)
            begin
              nxt_d.refPin = cur_q.head;
              nxt_d.refValid = 1'b1;
            end
          end
        end
        if (sendData || pinOk)
        begin
          if (dataCorrupt)
            sw = card_cmd_pkg::SW_CORRUPT;
          else if (pinOk && noInfoWarn)
            sw = card_cmd_pkg::SW_NO_INFO;
          else
            sw = card_cmd_pkg::SW_OK;
        end
        // errors and pin answers carry status only, k stays zero
        nxt_d.resp[k] = sw[15:8];
        nxt_d.resp[k + 1] = sw[7:0];
        nxt_d.respLen = 8'(k + 2);
        nxt_d.load = 1'b1;
        nxt_d.phase = SEND;
      end
      SEND:
      begin
        if (!cur_q.load && !respBus.busy)
        begin
          nxt_d.phase = COLLECT;
          nxt_d.cnt = '0;
          nxt_d.lc = 8'h00;
          nxt_d.leSeen = 1'b0;
          nxt_d.overrun = 1'b0;
        end
      end
      default:
        nxt_d.phase = COLLECT;
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cur_q <= '0;
      cur_q.tries <= TRY_BITS'(TRY_LIMIT);
    end
    else
      cur_q <= nxt_d;
  end

  assign respBus.load = cur_q.load;
  assign respBus.len = cur_q.respLen;
  assign respBus.bytes = cur_q.resp;

  resp_serializer #(.RESP_MAX(RESP_MAX)) serializer (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .buffer(respBus),
    .respValid(respValid),
    .respByte(respByte),
    .respLast(respLast),
    .respReady(respReady)
  );

  // one command at a time: input stalls until the answer has left
  assign cmdReady = (cur_q.phase == COLLECT);
  assign pinTryCounter = cur_q.tries;
  assign pinBlocked = (cur_q.tries == '0);
  assign referencePin = cur_q.refPin;
  assign referencePinValid = cur_q.refValid;
endmodule

/* sim/card_cmd_sva.sv */
// port-level assertions for the card command decoder
`timescale 1ns/10ps
module card_cmd_sva #(
  parameter int TRY_BITS = 4,
  parameter logic [3:0] TRY_LIMIT = 4'h3,
  parameter int PIN_BYTES = 8
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic cmdValid,
  input wire logic cmdEnd,
  input wire logic cmdReady,
  input wire logic respValid,
  input wire logic [7:0] respByte,
  input wire logic respLast,
  input wire logic respReady,
  input wire logic pinTryDecrement,
  input wire logic [TRY_BITS-1:0] pinTryCounter,
  input wire logic [PIN_BYTES-1:0][7:0] referencePin
);
  logic [8:0] idx_q;
  logic [7:0] first_q;
  logic [7:0] len_q;
  logic [7:0] prev_q;
  logic isData;
  logic isErr;
  assign isData = first_q inside {8'h80, 8'h79};
  assign isErr = first_q inside {8'h64, 8'h65, 8'h67, 8'h68, 8'h69, 8'h6A, 8'h6D};
  // index of the byte being accepted within one response
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      idx_q <= 9'h000;
      first_q <= 8'h00;
      len_q <= 8'h00;
      prev_q <= 8'h00;
    end
    else if (respValid && respReady)
    begin
      idx_q <= respLast ? 9'h000 : idx_q + 9'h001;
      if (idx_q == 9'h000)
        first_q <= respByte;
      if (idx_q == 9'h001)
        len_q <= respByte;
      prev_q <= respByte;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  sequence cmdTaken;
    cmdValid && cmdReady && cmdEnd;
  endsequence
  sequence lastTaken;
    respValid && respReady && respLast;
  endsequence
  chk_answer_time:
    assert property (cmdTaken |=> !cmdReady [*2] ##1 respValid)
    else $error("response not offered three cycles after command end");
  chk_byte_hold:
    assert property (respValid && !respReady |=> respValid && $stable(respByte))
    else $error("response byte changed before acceptance");
  chk_ready_excl:
    assert property (respValid |-> !cmdReady)
    else $error("command bytes taken while responding");
  chk_first_byte:
    assert property ($rose(respValid) |-> respByte inside {8'h80, 8'h79, 8'h90, 8'h62,
      8'h64, 8'h65, 8'h67, 8'h68, 8'h69, 8'h6A, 8'h6D})
    else $error("response opens with an unknown byte");
  chk_err_only_sw:
    assert property (lastTaken ##0 isErr |-> idx_q == 9'h001)
    else $error("error answer carries data");
  chk_data_len:
    assert property (lastTaken ##0 isData |-> idx_q == {1'b0, len_q} + 9'h003)
    else $error("tagged object length does not match bytes sent");
  chk_data_status:
    assert property (lastTaken ##0 isData |-> {prev_q, respByte} inside {16'h9000, 16'h6281})
    else $error("data answer ends with a bad status");
  chk_try_reload:
    assert property ($past(pinTryCounter) < pinTryCounter |-> pinTryCounter == TRY_LIMIT)
    else $error("try counter raised to a value other than the limit");
  chk_try_dec:
    assert property (pinTryDecrement && cmdReady && pinTryCounter != '0
      |=> pinTryCounter == $past(pinTryCounter) - 1'b1)
    else $error("try counter missed a decrement");
  chk_pin_steady:
    assert property (!$stable(referencePin) |-> !$past(cmdReady))
    else $error("reference pin changed outside command execution");
endmodule
bind card_txn_auth_pin_cmd_decoder card_cmd_sva #(.TRY_BITS(TRY_BITS), .TRY_LIMIT(TRY_LIMIT),
  .PIN_BYTES(PIN_BYTES)) i_card_cmd_sva (.sys_clk(sys_clk), .reset_n(reset_n),
  .cmdValid(cmdValid), .cmdEnd(cmdEnd), .cmdReady(cmdReady), .respValid(respValid),
  .respByte(respByte), .respLast(respLast), .respReady(respReady),
  .pinTryDecrement(pinTryDecrement), .pinTryCounter(pinTryCounter),
  .referencePin(referencePin));

/* sim/terminal_model.sv */
// terminal model: sends command bytes, collects response bytes
`timescale 1ns/10ps
module terminal_model (
  input wire logic sys_clk,
  output logic cmdValid,
  output logic [7:0] cmdByte,
  output logic cmdEnd,
  input wire logic cmdReady,
  input wire logic respValid,
  input wire logic [7:0] respByte,
  input wire logic respLast,
  output logic respReady,
  input wire logic slow
);
  logic [7:0] rxQ[$];
  int rxDone = 0;
  int seed = 33791;
  logic rdyN = 1'b0;
  initial
  begin
    cmdValid = 1'b0;
    cmdByte = 8'h00;
    cmdEnd = 1'b0;
    respReady = 1'b1;
  end
  // slow mode stalls the response side at random
  always @(posedge sys_clk)
    respReady <= slow ? 1'($random(seed)) : 1'b1;
  // negedge copy avoids racing the decoder's own edge
  always @(negedge sys_clk)
  begin
    rdyN = cmdReady;
    if (respValid && respReady)
    begin
      rxQ.push_back(respByte);
      if (respLast)
        rxDone++;
    end
  end
  task automatic send(input logic [7:0] q[$]);
    foreach (q[i])
    begin
      cmdValid <= 1'b1;
      cmdByte <= q[i];
      cmdEnd <= (i == q.size() - 1);
      do @(posedge sys_clk); while (rdyN !== 1'b1);
    end
    cmdValid <= 1'b0;
    cmdEnd <= 1'b0;
    // released line shows the inverse, not a stale copy
    cmdByte <= ~q[q.size()-1];
  endtask
endmodule

/* sim/tb.sv */
// self-checking bench for the card command decoder
`timescale 1ns/10ps
module tb;
  localparam logic [3:0] LIMIT = 4'h3;
  logic sys_clk, reset_n, cmdValid, cmdEnd, cmdReady, respValid, respLast, respReady, slow;
  logic [7:0] cmdByte, respByte, fileLocatorLen, signedLen;
  logic useFormatTwo, dataCorrupt, noInfoWarn, nvmFault, memFail, condsOk, signedValid;
  logic macOk, secStatusOk, pinCurrentOk, pinTryDecrement, pinBlocked, referencePinValid;
  logic [15:0] interchangeProfile;
  logic [15:0][7:0] fileLocatorList;
  logic [63:0][7:0] signedData;
  logic [3:0] pinTryCounter, mCnt;
  logic [7:0][7:0] referencePin, mPin;
  logic mPinOk;
  logic [7:0] cmdQ[$], expQ[$];
  int failCount = 0;
  int nCompared = 0;
  int seed = 33791;
  card_txn_auth_pin_cmd_decoder #(.TRY_LIMIT(LIMIT)) i_card_txn_auth_pin_cmd_decoder (.sys_clk,
    .reset_n, .cmdValid, .cmdByte, .cmdEnd, .cmdReady, .respValid, .respByte, .respLast,
    .respReady, .useFormatTwo, .interchangeProfile, .fileLocatorList, .fileLocatorLen,
    .signedValid, .signedData, .signedLen, .condsOk, .dataCorrupt, .noInfoWarn, .nvmFault,
    .memFail, .macOk, .secStatusOk, .pinCurrentOk, .pinTryDecrement, .pinTryCounter,
    .pinBlocked, .referencePin, .referencePinValid);
  terminal_model i_terminal_model (.sys_clk, .cmdValid, .cmdByte, .cmdEnd, .cmdReady,
    .respValid, .respByte, .respLast, .respReady, .slow);
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    nCompared++;
    if (got !== exp)
    begin
      failCount++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic printVerdict();
    $display("compared %0d mismatches %0d", nCompared, failCount);
    if (failCount == 0 && nCompared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // header h is class, instruction, p1, p2; fl sets the condition inputs
  task automatic run(input logic [31:0] h, input int lc, input int le, input logic [9:0] fl,
    input logic [15:0] sw);
    int n0;
    int n;
    logic [7:0] rx[$];
    @(posedge sys_clk);
    {useFormatTwo, dataCorrupt, noInfoWarn, nvmFault, memFail, condsOk, signedValid, macOk,
      secStatusOk, pinCurrentOk} <= fl;
    interchangeProfile <= 16'($random(seed));
    fileLocatorList <= {4{$random(seed)}};
    fileLocatorLen <= 8'({$random(seed)} % 16 + 1);
    signedData <= {16{$random(seed)}};
    signedLen <= 8'({$random(seed)} % 64 + 1);
    slow <= 1'($random(seed));
    @(posedge sys_clk);
    cmdQ = {h[31:24], h[23:16], h[15:8], h[7:0], 8'(lc)};
    for (int i = 0; i < lc; i++)
      cmdQ.push_back(8'($random(seed))); // opaque, as if enciphered
    if (h[23:16] == 8'hA8 && lc >= 2)
    begin
      cmdQ[5] = 8'h83;
      cmdQ[6] = 8'(lc - 2);
    end
    // more than one trailing byte runs past the expected length
    repeat (le)
      cmdQ.push_back(8'h00);
    expQ = {};
    if (sw inside {16'h9000, 16'h6281} && h[23:16] == 8'hA8)
    begin
      n = fileLocatorLen;
      if (useFormatTwo)
        expQ = {8'h79, 8'(6 + n), 8'h82, 8'h02, interchangeProfile[15:8],
          interchangeProfile[7:0], 8'h94, 8'(n)};
      else
        expQ = {8'h80, 8'(2 + n), interchangeProfile[15:8], interchangeProfile[7:0]};
      for (int i = 0; i < n; i++)
        expQ.push_back(fileLocatorList[i]);
    end
    if (sw inside {16'h9000, 16'h6281} && h[23:16] == 8'h88)
    begin
      n = signedLen;
      if (useFormatTwo)
        expQ = {8'h79, 8'(n + 3), 8'h9F, 8'h4B, 8'(n)};
      else
        expQ = {8'h80, 8'(n)};
      for (int i = 0; i < n; i++)
        expQ.push_back(signedData[i]);
    end
    expQ.push_back(sw[15:8]);
    expQ.push_back(sw[7:0]);
    if (h[23:16] == 8'h24 && sw[15:8] inside {8'h90, 8'h62})
    begin
      mCnt = LIMIT;
      if (h[7:0] != 8'h00)
      begin
        for (int j = 0; j < 8; j++)
          mPin[j] = cmdQ[5+j];
        mPinOk = 1'b1;
      end
    end
    n0 = i_terminal_model.rxDone;
    i_terminal_model.rxQ.delete();
    i_terminal_model.send(cmdQ);
    for (int t = 0; t < 3000 && i_terminal_model.rxDone == n0; t++)
      @(posedge sys_clk);
    @(negedge sys_clk);
    rx = i_terminal_model.rxQ;
    check("resp length", expQ.size(), rx.size());
    foreach (expQ[i])
      if (i < rx.size())
        check("resp byte", expQ[i], rx[i]);
    check("try counter", mCnt, pinTryCounter);
    check("blocked", mCnt == 4'h0, pinBlocked);
    check("pin", mPin, referencePin);
    check("pin valid", mPinOk, referencePinValid);
    $display("test done header %h status %h", h, sw);
  endtask
  initial
  begin
    #100000;
    failCount++;
    printVerdict();
  end
  initial
  begin
    reset_n = 1'b0;
    {useFormatTwo, dataCorrupt, noInfoWarn, nvmFault, memFail, condsOk, signedValid} = '0;
    {macOk, secStatusOk, pinCurrentOk, pinTryDecrement, slow} = '0;
    {interchangeProfile, fileLocatorList, fileLocatorLen, signedData, signedLen} = '0;
    mCnt = LIMIT;
    mPin = '0;
    mPinOk = 1'b0;
    repeat (4) @(posedge sys_clk);
    reset_n <= 1'b1;
    run(32'h80A8_0000, 2, 1, 10'h09F, 16'h9000);
    run(32'h80A8_0000, 7, 1, 10'h31F, 16'h6281);
    run(32'h80A8_0100, 2, 1, 10'h01F, 16'h6A81);
    run(32'h80A8_0000, 2, 0, 10'h01F, 16'h6700);
    run(32'h80A8_0000, 2, 1, 10'h00F, 16'h6985);
    run(32'h80A8_0000, 2, 1, 10'h05F, 16'h6400);
    run(32'h0088_0000, 4, 1, 10'h01F, 16'h9000);
    run(32'h0088_0000, 8, 1, 10'h31F, 16'h6281);
    run(32'h0088_0100, 4, 1, 10'h01F, 16'h6A86);
    run(32'h0C88_0000, 4, 1, 10'h01F, 16'h6882);
    run(32'h0088_0000, 0, 1, 10'h01F, 16'h6A80);
    run(32'h0088_0000, 4, 0, 10'h01F, 16'h6700);
    run(32'h0088_0000, 4, 2, 10'h01F, 16'h6700);
    run(32'h0088_0000, 4, 1, 10'h017, 16'h6985);
    run(32'h8C24_0001, 16, 0, 10'h01F, 16'h6A88);
    run(32'h8424_0002, 16, 0, 10'h09F, 16'h6200);
    run(32'h8C24_0001, 16, 0, 10'h01F, 16'h9000);
    @(posedge sys_clk);
    pinTryDecrement <= 1'b1;
    repeat (4) @(posedge sys_clk);
    pinTryDecrement <= 1'b0;
    // four pulses on three tries: counter floors at zero
    mCnt = 4'h0;
    run(32'h80CA_0000, 2, 1, 10'h01F, 16'h6D00);
    run(32'h8424_0000, 8, 0, 10'h01F, 16'h9000);
    run(32'h8424_0003, 8, 0, 10'h01F, 16'h6A86);
    run(32'h8424_0000, 4, 0, 10'h01F, 16'h6987);
    run(32'h8424_0000, 8, 1, 10'h01F, 16'h6988);
    run(32'h8424_0001, 8, 0, 10'h01F, 16'h6988);
    run(32'h8424_0000, 8, 0, 10'h01D, 16'h6982);
    run(32'h8C24_0001, 16, 0, 10'h01E, 16'h6984);
    run(32'h8424_0000, 8, 0, 10'h03F, 16'h6581);
    run(32'h8424_0000, 8, 0, 10'h11F, 16'h6281);
    printVerdict();
  end
endmodule
